// ==== uls_line_status.sv ====
/*
 * Upper line status flags of one serial channel: receive queue error
 * summary, transmitter all empty and holding empty with its interrupt,
 * plus the line error interrupt, behind an AHB-Lite slave.
 * Assumes the transmitter, receiver queue and shifter run on the same
 * clock and hand their strobes and levels straight in.
 */
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module uls_line_status
	import uls_pkg::*;
#(
	parameter int RXC_W = 7	// Width of the error-tag entry count
) (
	input  wire logic             clock,
	input  wire logic             rst,
	// AHB-Lite slave
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic                  hreadyout,
	output logic      [31:0]      hrdata,
	output logic                  hresp,
	// Transmit side
	input  wire logic             hold_load,
	input  wire logic             hold_move,
	input  wire logic             shift_busy,
	input  wire logic             txq_empty,
	// Receive side
	input  wire logic [RXC_W-1:0] rx_err_count,
	input  wire logic [4:0]       rx_low_status,
	output logic                  ls_read,
	// Interrupts
	output logic                  holding_irq,
	output logic                  line_irq,
	output logic                  irq
);
	logic [2:0]          ctrl_ff;	// Control register
	logic                hold_empty_ff;	// Holding empty flag
	logic                nxt_hold_empty;	// Its next value
	logic                all_empty_ff;	// Transmitter all empty flag
	logic                nxt_all_empty;	// Its next value
	logic                rxerr_ff;	// Receive queue error summary
	logic                line_err_ff;	// Error level seen last cycle
	logic                hold_irq_ff;	// Holding empty request
	logic                line_irq_ff;	// Line status request
	logic                ls_read_ff;	// Status read strobe
	logic                wr_pend_ff;	// Write data phase pending
	logic [5:0]          wr_idx_ff;	// Index of pending write
	logic [31:0]         hrdata_ff;	// Read data
	logic                hreadyout_ff;	// Always ready
	logic                hresp_ff;	// Always OKAY
	logic                accept;	// Address phase taken
	logic                line_err;	// Any receive error bit
	logic [7:0]          ls_value;	// Assembled line_status
	logic [ULS_EV_W-1:0] events;	// Event pulses
	logic [ULS_EV_W-1:0] ev_status;	// Sticky status
	logic [ULS_EV_W-1:0] ev_enable;	// Event mask
	logic                irq_ff;	// Summary interrupt
	logic                qmode;	// Queue mode selected

	// One decoder for every register write, so all targets agree on
	// which data phase belongs to them
	function automatic logic wr_hit(input logic pend,
		input logic [5:0] have, input logic [5:0] want);
		return pend && (have == want);
	endfunction

	assign qmode    = ctrl_ff[ULS_CTRL_QMODE];
	assign accept   = hsel & htrans[1] & hready;
	assign line_err = |rx_low_status[4:1];

	// Outputs straight from flip-flops
	assign hreadyout   = hreadyout_ff;
	assign hrdata      = hrdata_ff;
	assign hresp       = hresp_ff;
	assign ls_read     = ls_read_ff;
	assign holding_irq = hold_irq_ff;
	assign line_irq    = line_irq_ff;
	assign irq         = irq_ff;

	// Line status as software sees it; lower bits come from the receiver
	always_comb begin
		ls_value              = {3'h0, rx_low_status};
		ls_value[ULS_LS_RXERR] = rxerr_ff;
		ls_value[ULS_LS_ALL_EMPTY]  = all_empty_ff;
		ls_value[ULS_LS_HOLD_EMPTY] = hold_empty_ff;
	end

	// Holding empty next value; read strobes never enter here
	always_comb begin
		nxt_hold_empty = hold_empty_ff;
		if (qmode) begin
			nxt_hold_empty = txq_empty;
		end else if (hold_load) begin
			// A load in the same cycle as a move refills the register
			nxt_hold_empty = 1'b0;
		end else if (hold_move) begin
			nxt_hold_empty = 1'b1;
		end
	end

	// Transmitter all empty: holding side and shifter both idle.
	// Non-queue mode uses the next holding value, so the two flags
	// never disagree for a cycle after a move or a load
	always_comb begin
		if (qmode) begin
			nxt_all_empty = txq_empty & ~shift_busy;
		end else begin
			nxt_all_empty = nxt_hold_empty & ~shift_busy;
		end
	end

	// Flag registers; reset shows an empty transmitter. No bus read
	// reaches them, so polling the status can never lose a flag
	always_ff @(posedge clock) begin
		if (rst) begin
			hold_empty_ff <= ULS_HOLD_EMPTY_RST;
			all_empty_ff  <= ULS_ALL_EMPTY_RST;
		end else begin
			hold_empty_ff <= nxt_hold_empty;
			all_empty_ff  <= nxt_all_empty;
		end
	end

	// Error summary counts tagged entries only in queue mode
	// Outside queue mode the tag count is ignored entirely
	always_ff @(posedge clock) begin
		if (rst) begin
			rxerr_ff <= ULS_RXERR_RST;
		end else begin
			rxerr_ff <= qmode & (rx_err_count != '0);
		end
	end

	// Interrupt request levels
	// Built from the next holding value so request and flag rise together
	always_ff @(posedge clock) begin
		if (rst) begin
			hold_irq_ff <= 1'b0;
			line_irq_ff <= 1'b0;
		end else begin
			hold_irq_ff <= nxt_hold_empty & ctrl_ff[ULS_CTRL_HOLD_IE];
			line_irq_ff <= line_err & ctrl_ff[ULS_CTRL_LINE_IE];
		end
	end

	// Previous error level, for edge events
	always_ff @(posedge clock) begin
		if (rst) begin
			line_err_ff <= 1'b0;
		end else begin
			line_err_ff <= line_err;
		end
	end

	// Rising edges become sticky events; a flag that stays set is
	// reported once, not every cycle
	always_comb begin
		events                   = '0;
		events[ULS_EV_HOLD]      = nxt_hold_empty & ~hold_empty_ff;
		events[ULS_EV_ALL_EMPTY] = nxt_all_empty & ~all_empty_ff;
		events[ULS_EV_LINE] = line_err & ~line_err_ff;
	end

	uls_irq_events u_events (
		.clock     (clock),
		.rst       (rst),
		.event_in  (events),
		.clr_we    (wr_hit(wr_pend_ff, wr_idx_ff, ULS_ICLR_IDX)),
		.en_we     (wr_hit(wr_pend_ff, wr_idx_ff, ULS_IEN_IDX)),
		.wdata     (hwdata[ULS_EV_W-1:0]),
		.status_ff (ev_status),
		.enable_ff (ev_enable),
		.irq_ff    (irq_ff)
	);

	// Bus handshake: zero wait states, always OKAY. Ready stays high
	// through reset, so a master that starts right after release is
	// never stalled
	always_ff @(posedge clock) begin
		if (rst) begin
			hreadyout_ff <= 1'b1;
			hresp_ff     <= ULS_HRESP_OKAY;
		end else begin
			hreadyout_ff <= 1'b1;
			hresp_ff     <= ULS_HRESP_OKAY;
		end
	end

	// Capture write address phase; data follows next cycle
	// Only the index is kept; hwdata is read in the data phase itself
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff  <= '0;
		end else begin
			wr_pend_ff <= accept & hwrite;
			if (accept) begin
				wr_idx_ff <= uls_idx(haddr);
			end
		end
	end

	// Control register; writes to line_status are dropped, being
	// reserved for test
	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_ff <= ULS_CTRL_RST;
		end else if (wr_hit(wr_pend_ff, wr_idx_ff, ULS_CTRL_IDX)) begin
			ctrl_ff <= hwdata[2:0];
		end
	end

	// Read data is fetched at the address phase, unmapped reads zero
	// A flag that moves during the data phase shows on the next read
	always_ff @(posedge clock) begin
		if (rst) begin
			hrdata_ff <= '0;
		end else if (accept && !hwrite) begin
			case (uls_idx(haddr))
				ULS_CTRL_IDX:  hrdata_ff <= {29'h0, ctrl_ff};
				ULS_ISTAT_IDX: hrdata_ff <= {29'h0, ev_status};
				ULS_IEN_IDX:   hrdata_ff <= {29'h0, ev_enable};
				ULS_LS_IDX:    hrdata_ff <= {24'h0, ls_value};
				default:       hrdata_ff <= '0;
			endcase
		end
	end

	// Read strobe lets the receiver clear its own lower bits
	always_ff @(posedge clock) begin
		if (rst) begin
			ls_read_ff <= 1'b0;
		end else begin
			ls_read_ff <= accept & ~hwrite & (uls_idx(haddr) == ULS_LS_IDX);
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// Receive queue error summary
	rxerr_off_a: assert property (!qmode |=> !rxerr_ff)
		else $error("error summary set outside queue mode");
	rxerr_sum_a: assert property (
		qmode && rx_err_count != '0 |=> rxerr_ff)
		else $error("error summary missed tagged entry");
	rxerr_clear_a: assert property (
		qmode && rx_err_count == '0 |=> !rxerr_ff)
		else $error("error summary stuck without tagged entry");

	// Transmitter all empty; it can never outrun the holding flag
	empty_busy_a: assert property (shift_busy |=> !all_empty_ff)
		else $error("all empty while shifter busy");
	empty_idle_a: assert property (
		qmode && txq_empty && !shift_busy |=> all_empty_ff)
		else $error("all empty not set when idle");
	empty_hold_a: assert property (all_empty_ff |-> hold_empty_ff)
		else $error("all empty while holding side full");

	// Holding empty flag and its request
	hold_irq_a: assert property (##1 hold_irq_ff ==
		(hold_empty_ff && $past(ctrl_ff[ULS_CTRL_HOLD_IE])))
		else $error("holding request wrong");
	hold_quiet_a: assert property (
		!ctrl_ff[ULS_CTRL_HOLD_IE] |=> !hold_irq_ff)
		else $error("holding request without enable");
	hold_move_a: assert property (
		!qmode && hold_move && !hold_load |=> hold_empty_ff)
		else $error("move did not set holding empty");
	hold_load_a: assert property (
		!qmode && hold_load |=> !hold_empty_ff ##1 (hold_empty_ff ||
		!$past(hold_move) || $past(hold_load) || $past(qmode)))
		else $error("load did not clear holding empty");
	hold_queue_a: assert property (
		qmode |=> hold_empty_ff == $past(txq_empty))
		else $error("holding empty not tracking queue");

	// Line status interrupt follows the error level
	line_irq_a: assert property (
		line_err && ctrl_ff[ULS_CTRL_LINE_IE] |=> line_irq_ff)
		else $error("line interrupt missing");
	line_quiet_a: assert property (!line_err |=> !line_irq_ff)
		else $error("line interrupt without error");

	// Side effects of bus transfers
	read_keep_a: assert property (
		!qmode && !hold_load && !hold_move |=> $stable(hold_empty_ff))
		else $error("holding empty changed without cause");
	ls_strobe_a: assert property (
		accept && !hwrite && uls_idx(haddr) == ULS_LS_IDX |=> ls_read_ff)
		else $error("line status read not signalled");
	ctrl_write_a: assert property (
		wr_hit(wr_pend_ff, wr_idx_ff, ULS_CTRL_IDX) |=>
		ctrl_ff == $past(hwdata[2:0]))
		else $error("control write lost");

endmodule // uls_line_status
`default_nettype wire

// ==== uls_pkg.sv ====
/*
 * Constants for the line status flag block: register indices, field
 * positions, reset values and the AHB-Lite encodings used by the slave.
 * Assumes a single 100 MHz clock and a 32-bit AHB-Lite register bus.
 */
package uls_pkg;

	// Register word indices; byte address is index times four
	localparam logic [5:0] ULS_CTRL_IDX  = 6'h00;	// Control
	localparam logic [5:0] ULS_ISTAT_IDX = 6'h01;	// Sticky events, RO
	localparam logic [5:0] ULS_ICLR_IDX  = 6'h02;	// Event clear, WO
	localparam logic [5:0] ULS_IEN_IDX   = 6'h03;	// Event enable
	localparam logic [5:0] ULS_LS_IDX    = 6'h05;	// line_status, RO

	// Control fields
	localparam int ULS_CTRL_QMODE   = 0;	// Queue (FIFO) mode
	localparam int ULS_CTRL_HOLD_IE = 1;	// Holding empty irq enable
	localparam int ULS_CTRL_LINE_IE = 2;	// Line status irq enable
	localparam logic [2:0] ULS_CTRL_RST = 3'h0;

	// line_status fields
	localparam int ULS_LS_RXERR = 7;	// Receive queue error summary
	localparam int ULS_LS_ALL_EMPTY  = 6;	// Transmitter all empty
	localparam int ULS_LS_HOLD_EMPTY = 5;	// Holding empty
	localparam logic ULS_RXERR_RST      = 1'b0;
	localparam logic ULS_ALL_EMPTY_RST  = 1'b1;
	localparam logic ULS_HOLD_EMPTY_RST = 1'b1;

	// Event bits in status / clear / enable
	localparam int ULS_EV_HOLD = 0;	// Holding empty rose
	localparam int ULS_EV_ALL_EMPTY = 1;	// Transmitter all empty rose
	localparam int ULS_EV_LINE = 2;	// Receive error appeared
	localparam int ULS_EV_W    = 3;

	// AHB-Lite encodings
	localparam logic       ULS_HRESP_OKAY = 1'b0;

	// Word index of a byte address
	function automatic logic [5:0] uls_idx(input logic [31:0] a);
		return a[7:2];
	endfunction

endpackage

// ==== uls_irq_events.sv ====
/*
 * Sticky event status with write-one-to-clear and an enable mask,
 * folded onto one level interrupt. Assumes event pulses and write
 * strobes come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module uls_irq_events
	import uls_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic [ULS_EV_W-1:0] event_in,	// One-cycle events
	input  wire logic                clr_we,	// Clear write strobe
	input  wire logic                en_we,	// Enable write strobe
	input  wire logic [ULS_EV_W-1:0] wdata,	// Write data
	output logic      [ULS_EV_W-1:0] status_ff,	// Sticky bits
	output logic      [ULS_EV_W-1:0] enable_ff,	// Mask
	output logic                     irq_ff	// Level interrupt
);
	logic [ULS_EV_W-1:0] nxt_status;	// Status after this cycle

	// A new event beats a clear in the same cycle so none is lost
	always_comb begin
		nxt_status = (status_ff & ~(clr_we ? wdata : '0)) | event_in;
	end

	// Sticky status
	always_ff @(posedge clock) begin
		if (rst) begin
			status_ff <= '0;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// Enable mask
	always_ff @(posedge clock) begin
		if (rst) begin
			enable_ff <= '0;
		end else if (en_we) begin
			enable_ff <= wdata;
		end
	end

	// Interrupt follows the masked status one cycle later
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(status_ff & enable_ff);
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	set_wins_a: assert property ((event_in != '0) |=>
		((status_ff & $past(event_in)) == $past(event_in)))
		else $error("event lost against clear");
	irq_level_a: assert property (
		##1 irq_ff == $past(|(status_ff & enable_ff)))
		else $error("interrupt does not follow masked status");

endmodule // uls_irq_events
`default_nettype wire

// ==== uls_host_model.sv ====
/*
 * Host processor model: an AHB-Lite master issuing single word transfers.
 * Assumes one slave whose hreadyout is fed back as hready.
 */
`timescale 1ns/1ps
`default_nettype none
module uls_host_model (
	input  wire logic        clock,
	input  wire logic        hready,	// Bus ready from the slave
	input  wire logic [31:0] hrdata,	// Read data in data phase
	output var logic         hsel,	// Slave select
	output var logic  [31:0] haddr,	// Byte address
	output var logic  [1:0]  htrans,	// NONSEQ or IDLE
	output var logic         hwrite,	// Direction
	output var logic  [2:0]  hsize,	// Always a word
	output var logic  [31:0] hwdata	// Write data
);
	// Idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// One transfer; never assumes a latency, only hready ends a phase
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] rd);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= w ? d : ~hwdata;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
		// Released lines show a changed value, not the stale one
		hwdata <= ~hwdata;
		haddr <= ~a;
	endtask
endmodule // uls_host_model
`default_nettype wire

// ==== uls_line_status_flags_bench.sv ====
/*
 * Self-checking bench for the line status flags behind AHB-Lite.
 * Assumes the host model above and the design's package constants.
 */
`timescale 1ns/1ps
`default_nettype none
module uls_line_status_flags_bench
	import uls_pkg::*;
;
	localparam logic [31:0] A_CTRL = {24'h0, ULS_CTRL_IDX, 2'h0};
	localparam logic [31:0] A_IST  = {24'h0, ULS_ISTAT_IDX, 2'h0};
	localparam logic [31:0] A_ICLR = {24'h0, ULS_ICLR_IDX, 2'h0};
	localparam logic [31:0] A_IEN  = {24'h0, ULS_IEN_IDX, 2'h0};
	localparam logic [31:0] A_LS   = {24'h0, ULS_LS_IDX, 2'h0};
	logic        clock, rst, hsel, hwrite, hold_load, hold_move;
	logic        shift_busy, txq_empty, ls_read, holding_irq;
	logic        line_irq, irq, hready, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [6:0]  rx_err_count;	// Error-tagged entries in receive queue
	logic [4:0]  rx_low_status;	// Receiver's own low bits
	int          err_count, num_checks, cyc, ls_reads;
	logic [31:0] scratch;	// Read data of writes, unused

	logic        hreadyout_w;	// Slave ready output
	// Single slave: its ready is the bus ready
	assign hready = hreadyout_w;

	uls_line_status i_dut (.clock(clock), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout_w),
		.hrdata(hrdata), .hresp(hresp), .hold_load(hold_load),
		.hold_move(hold_move), .shift_busy(shift_busy),
		.txq_empty(txq_empty), .rx_err_count(rx_err_count),
		.rx_low_status(rx_low_status), .ls_read(ls_read),
		.holding_irq(holding_irq), .line_irq(line_irq), .irq(irq));

	uls_host_model i_host (.clock(clock), .hready(hready),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Hang guard: the run needs about a hundred cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			close_out();
		end
	end

	// One strobe cycle per line_status read is expected
	always @(posedge clock) begin
		if (ls_read === 1'b1)
			ls_reads++;
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rd_chk(input string nm, input logic [31:0] a,
		input logic [31:0] e);
		logic [31:0] d;
		i_host.xfer(1'b0, a, 32'h0, d);
		chk(nm, e, d);
		chk("hresp", {31'h0, ULS_HRESP_OKAY}, {31'h0, hresp});
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, scratch);
	endtask

	// One-cycle transmit strobes, launched off a rising edge
	task automatic strobe(input logic ld, input logic mv);
		@(posedge clock);
		hold_load <= ld;
		hold_move <= mv;
		@(posedge clock);
		hold_load <= 1'b0;
		hold_move <= 1'b0;
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		hold_load = 1'b0;
		hold_move = 1'b0;
		shift_busy = 1'b0;
		txq_empty = 1'b1;
		rx_err_count = 7'h00;
		rx_low_status = 5'h00;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		rd_chk("ls reset", A_LS, 32'h60);
		rd_chk("ctrl reset", A_CTRL, 32'h0);
		rd_chk("unmapped", 32'h40, 32'h0);
		strobe(1'b1, 1'b0);
		rd_chk("ls loaded", A_LS, 32'h00);
		@(posedge clock) shift_busy <= 1'b1;
		strobe(1'b0, 1'b1);
		rd_chk("ls moved", A_LS, 32'h20);
		rd_chk("ls reread", A_LS, 32'h20);
		@(posedge clock) shift_busy <= 1'b0;
		rx_err_count <= 7'h03;
		rx_low_status <= 5'h02;
		rd_chk("ls drained", A_LS, 32'h62);
		wr(A_CTRL, 32'h7);
		rd_chk("ls queue err", A_LS, 32'he2);
		@(negedge clock);
		chk("holding_irq", 32'h1, {31'h0, holding_irq});
		chk("line_irq", 32'h1, {31'h0, line_irq});
		@(posedge clock) txq_empty <= 1'b0;
		rx_err_count <= 7'h00;
		rx_low_status <= 5'h00;
		strobe(1'b0, 1'b1);
		rd_chk("ls queue busy", A_LS, 32'h00);
		@(negedge clock);
		chk("holding_irq off", 32'h0, {31'h0, holding_irq});
		chk("line_irq off", 32'h0, {31'h0, line_irq});
		@(posedge clock) txq_empty <= 1'b1;
		rd_chk("ls queue empty", A_LS, 32'h60);
		// Events: clear, enable, provoke, mask, clear again
		wr(A_CTRL, 32'h0);
		wr(A_ICLR, 32'h7);
		wr(A_IEN, 32'h1);
		rd_chk("events idle", A_IST, 32'h0);
		strobe(1'b1, 1'b0);
		strobe(1'b0, 1'b1);
		wr(A_IST, 32'h0);
		rd_chk("events set", A_IST, 32'h3);
		@(negedge clock);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(A_IEN, 32'h0);
		rd_chk("enable off", A_IEN, 32'h0);
		@(negedge clock);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(A_ICLR, 32'h1);
		rd_chk("events cleared", A_IST, 32'h2);
		@(posedge clock) rx_low_status <= 5'h04;
		rd_chk("line event", A_IST, 32'h6);
		@(negedge clock);
		chk("line_irq masked", 32'h0, {31'h0, line_irq});
		chk("ls_read pulses", 32'h8, ls_reads);
		close_out();
	end
endmodule // uls_line_status_flags_bench
`default_nettype wire
